// ### hdl/nft_params.svh
// Offsets, field positions, reset values and tick rates of the timer unit
// Function
// - General timers count on 13.56 MHz, 212 kHz or wake-timer underflow ticks.
// - Every counter is 16 bits, readable as high and low byte.
// - Each timer has a 16-bit reload value in high and low bytes.
// - Wake-up timer always counts on slow oscillator ticks.
// - Global control starts or stops the four timers and shows running state.
// - A running timer decrements once per tick of its selected clock.
// - At zero, the interrupt is raised on the next counting tick.
// - An enabled underflow is signalled on the interrupt request pin.
// - Software can both set and clear each timer interrupt flag.
// - At underflow, stop at zero or reload and continue per auto reload option.
// - Running flag reads one exactly while the timer counts.
// - Immediate action with running one starts; with running zero stops.
// - Setting the start bit in timer configuration also starts the timer.
// - A started timer begins decrementing on its configured start event.
// - A stop event before underflow stops the timer without interrupt.
// - A stop event freezes the count for elapsed time computation.
// - Wake-up timer ends standby; may return to standby when no card found.
// - Without auto wake the device stays powered after an empty wake-up.
// - Auto reload with interrupt enabled gives a request every period.
// - Timer flags sit in the second interrupt flag register, set on underflow.
// - Any-interrupt flag is set while any enabled source is set.
`ifndef NFT_PARAMS_SVH
`define NFT_PARAMS_SVH

`define NFT_OFS_GLOBAL_CTRL 8'h00
`define NFT_OFS_INT_FLAG 8'h04
`define NFT_OFS_INT_EN 8'h08
`define NFT_OFS_POWER 8'h0C
`define NFT_TMR_BASE_SLOT 3'h1
`define NFT_SUB_CTRL 3'h0
`define NFT_SUB_RLD_HI 3'h1
`define NFT_SUB_RLD_LO 3'h2
`define NFT_SUB_CNT_HI 3'h3
`define NFT_SUB_CNT_LO 3'h4

`define NFT_CTRL_CLKSEL 0
`define NFT_CTRL_AUTORLD 2
`define NFT_CTRL_START 3
`define NFT_CTRL_STARTEV 4
`define NFT_CTRL_STOPEV 5
`define NFT_CTRL_AUTOWAKE 6
`define NFT_CTRL_HALT 7
`define NFT_GC_RUN 0
`define NFT_GC_IMM 4
`define NFT_GC_WAIT 8
`define NFT_GC_WAKE_RUN 12
`define NFT_IF_ANY 6
`define NFT_IF_SETMODE 7
`define NFT_IE_PIN 6
`define NFT_PWR_STANDBY 0
`define NFT_PWR_CHECK 1

`define NFT_RST_RELOAD 16'hFFFF
`define NFT_CLK_KHZ 100000
`define NFT_FAST_KHZ 13560
`define NFT_SLOW_KHZ 212

`endif

// ### hdl/nft_pkg.sv
// Types shared by the timer unit modules
package nft_pkg;

    typedef struct packed {
        logic auto_wake;
        logic stop_evt_en;
        logic start_evt_en;
        logic auto_reload;
        logic [1:0] clk_sel;
    } nft_tcfg_t;

    typedef struct packed {
        logic [15:0] count;
        logic counting;
        logic waiting;
    } nft_tmr_st_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } nft_apb_req_t;

    typedef enum logic [1:0] {NFT_AWAKE, NFT_STANDBY, NFT_CHECK} nft_pwr_t;

    typedef struct packed {
        nft_tcfg_t [4:0] cfg;
        logic [4:0][15:0] reload;
        logic [4:0] int_flag;
        logic [4:0] int_en;
        logic pin_en;
        logic [31:0] prdata;
        logic pslverr;
        nft_pwr_t pwr;
        logic [2:0] osc_sync;
        logic [16:0] fast_acc;
        logic [16:0] slow_acc;
    } nft_state_t;

endpackage : nft_pkg

// ### hdl/nft_timer_unit.sv
// Timer unit top: APB registers, tick generation, five timers, wake control
`timescale 1ns/1ns
`include "nft_params.svh"
module nft_timer_unit (
    input wire logic pclk,
    input wire logic presetn,
    input nft_pkg::nft_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_osc,
    input wire logic [3:0] start_evt,
    input wire logic [3:0] stop_evt,
    input wire logic card_found,
    input wire logic detect_done,
    output logic irq,
    output logic standby
);
    nft_pkg::nft_state_t q;
    nft_pkg::nft_state_t d;

    logic [4:0][15:0] count;
    logic [4:0] counting;
    logic [4:0] waiting;
    logic [4:0] underflow;
    logic [4:0] start;
    logic [4:0] stop;
    logic [4:0] tick;
    logic [4:0] start_ev5;
    logic [4:0] stop_ev5;
    logic fast_tick;
    logic slow_tick;
    logic osc_tick;
    logic any_flag;

    assign start_ev5 = {1'b0, start_evt};
    assign stop_ev5 = {1'b0, stop_evt};

    // Fractional dividers from pclk; ticks jitter by one pclk but average exact
    assign fast_tick = (q.fast_acc + 17'(`NFT_FAST_KHZ)) >= 17'(`NFT_CLK_KHZ);
    assign slow_tick = (q.slow_acc + 17'(`NFT_SLOW_KHZ)) >= 17'(`NFT_CLK_KHZ);
    // Rising edge of the synchronised slow oscillator
    assign osc_tick = q.osc_sync[1] && !q.osc_sync[2];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            case (q.cfg[i].clk_sel)
                2'h0: tick[i] = fast_tick;
                2'h1: tick[i] = slow_tick;
                2'h2: tick[i] = underflow[4];
                default: tick[i] = 1'b0;
            endcase
        end
        tick[4] = osc_tick;
    end

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_tmr
            nft_tmr u_tmr (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick[g]),
                .start(start[g]),
                .stop(stop[g]),
                .start_evt(start_ev5[g]),
                .stop_evt(stop_ev5[g]),
                .cfg(q.cfg[g]),
                .reload(q.reload[g]),
                .count(count[g]),
                .counting(counting[g]),
                .waiting(waiting[g]),
                .underflow(underflow[g])
            );
        end
    endgenerate

    assign any_flag = |(q.int_flag & q.int_en);

    always_comb begin
        logic setup;
        logic wr;
        logic [2:0] slot;
        logic [2:0] sub;
        logic [2:0] idx;
        logic tmr_hit;
        logic [31:0] rd;
        logic err;
        logic [4:0] fl_set;
        logic [4:0] fl_clr;
        setup = apb_req.psel && !apb_req.penable;
        wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
        slot = apb_req.paddr[7:5];
        sub = apb_req.paddr[4:2];
        idx = slot - `NFT_TMR_BASE_SLOT;
        tmr_hit = (slot >= `NFT_TMR_BASE_SLOT) && (idx < 3'h5) && (sub <= `NFT_SUB_CNT_LO);
        rd = 32'h0000_0000;
        err = 1'b0;
        fl_set = 5'h00;
        fl_clr = 5'h00;
        start = 5'h00;
        stop = 5'h00;
        d = q;

        d.osc_sync = {q.osc_sync[1:0], slow_osc};
        d.fast_acc = q.fast_acc + 17'(`NFT_FAST_KHZ);
        if (fast_tick) begin
            d.fast_acc = q.fast_acc + 17'(`NFT_FAST_KHZ) - 17'(`NFT_CLK_KHZ);
        end
        d.slow_acc = q.slow_acc + 17'(`NFT_SLOW_KHZ);
        if (slow_tick) begin
            d.slow_acc = q.slow_acc + 17'(`NFT_SLOW_KHZ) - 17'(`NFT_CLK_KHZ);
        end

        // Address decode shared by read (setup) and write (access)
        if (apb_req.paddr[1:0] != 2'h0) begin
            err = 1'b1;
        end else if (slot == 3'h0) begin
            // Full byte address so the 8-bit offsets match without truncation
            case (apb_req.paddr)
                `NFT_OFS_GLOBAL_CTRL: begin
                    rd[`NFT_GC_RUN +: 4] = counting[3:0];
                    rd[`NFT_GC_WAIT +: 4] = waiting[3:0];
                    rd[`NFT_GC_WAKE_RUN] = counting[4];
                end
                `NFT_OFS_INT_FLAG: begin
                    rd[4:0] = q.int_flag;
                    rd[`NFT_IF_ANY] = any_flag;
                end
                `NFT_OFS_INT_EN: begin
                    rd[4:0] = q.int_en;
                    rd[`NFT_IE_PIN] = q.pin_en;
                end
                `NFT_OFS_POWER: begin
                    rd[`NFT_PWR_STANDBY] = (q.pwr == nft_pkg::NFT_STANDBY);
                    rd[`NFT_PWR_CHECK] = (q.pwr == nft_pkg::NFT_CHECK);
                end
                default: err = 1'b1;
            endcase
        end else if (tmr_hit) begin
            case (sub)
                `NFT_SUB_CTRL: begin
                    rd[`NFT_CTRL_CLKSEL +: 2] = q.cfg[idx].clk_sel;
                    rd[`NFT_CTRL_AUTORLD] = q.cfg[idx].auto_reload;
                    rd[`NFT_CTRL_STARTEV] = q.cfg[idx].start_evt_en;
                    rd[`NFT_CTRL_STOPEV] = q.cfg[idx].stop_evt_en;
                    rd[`NFT_CTRL_AUTOWAKE] = q.cfg[idx].auto_wake;
                end
                `NFT_SUB_RLD_HI: rd[7:0] = q.reload[idx][15:8];
                `NFT_SUB_RLD_LO: rd[7:0] = q.reload[idx][7:0];
                `NFT_SUB_CNT_HI: rd[7:0] = count[idx][15:8];
                `NFT_SUB_CNT_LO: rd[7:0] = count[idx][7:0];
                default: err = 1'b1;
            endcase
        end else begin
            err = 1'b1;
        end

        // Read data and error captured in setup, presented in access
        if (setup) begin
            d.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
            d.pslverr = err;
        end

        if (wr && !err) begin
            if (slot == 3'h0) begin
                case (apb_req.paddr)
                    `NFT_OFS_GLOBAL_CTRL: begin
                        for (int i = 0; i < 4; i++) begin
                            if (apb_req.pwdata[`NFT_GC_IMM + i]) begin
                                start[i] = apb_req.pwdata[`NFT_GC_RUN + i];
                                stop[i] = !apb_req.pwdata[`NFT_GC_RUN + i];
                            end
                        end
                    end
                    `NFT_OFS_INT_FLAG: begin
                        if (apb_req.pwdata[`NFT_IF_SETMODE]) begin
                            fl_set = apb_req.pwdata[4:0];
                        end else begin
                            fl_clr = apb_req.pwdata[4:0];
                        end
                    end
                    `NFT_OFS_INT_EN: begin
                        d.int_en = apb_req.pwdata[4:0];
                        d.pin_en = apb_req.pwdata[`NFT_IE_PIN];
                    end
                    `NFT_OFS_POWER: begin
                        if (apb_req.pwdata[`NFT_PWR_STANDBY] && q.pwr == nft_pkg::NFT_AWAKE) begin
                            d.pwr = nft_pkg::NFT_STANDBY;
                        end
                    end
                    default: d.pwr = q.pwr;
                endcase
            end else begin
                case (sub)
                    `NFT_SUB_CTRL: begin
                        d.cfg[idx].clk_sel = apb_req.pwdata[`NFT_CTRL_CLKSEL +: 2];
                        d.cfg[idx].auto_reload = apb_req.pwdata[`NFT_CTRL_AUTORLD];
                        d.cfg[idx].start_evt_en = apb_req.pwdata[`NFT_CTRL_STARTEV];
                        d.cfg[idx].stop_evt_en = apb_req.pwdata[`NFT_CTRL_STOPEV];
                        d.cfg[idx].auto_wake = apb_req.pwdata[`NFT_CTRL_AUTOWAKE];
                        // This start still takes its start event choice from the previous settings
                        start[idx] = apb_req.pwdata[`NFT_CTRL_START];
                        stop[idx] = apb_req.pwdata[`NFT_CTRL_HALT]
                            && !apb_req.pwdata[`NFT_CTRL_START];
                    end
                    `NFT_SUB_RLD_HI: d.reload[idx][15:8] = apb_req.pwdata[7:0];
                    `NFT_SUB_RLD_LO: d.reload[idx][7:0] = apb_req.pwdata[7:0];
                    default: d.reload = q.reload;
                endcase
            end
        end

        // Hardware set beats a same-cycle software clear
        d.int_flag = (q.int_flag & ~fl_clr) | fl_set | underflow;

        // Wake-up sequencing around standby
        case (q.pwr)
            nft_pkg::NFT_AWAKE: begin
                d.pwr = d.pwr;
            end
            nft_pkg::NFT_STANDBY: begin
                if (underflow[4]) begin
                    d.pwr = nft_pkg::NFT_CHECK;
                end
            end
            nft_pkg::NFT_CHECK: begin
                if (detect_done) begin
                    if (!card_found && q.cfg[4].auto_wake) begin
                        d.pwr = nft_pkg::NFT_STANDBY;
                    end else begin
                        d.pwr = nft_pkg::NFT_AWAKE;
                    end
                end
            end
            default: d.pwr = nft_pkg::NFT_AWAKE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            for (int i = 0; i < 5; i++) begin
                q.reload[i] <= `NFT_RST_RELOAD;
            end
            q.pwr <= nft_pkg::NFT_AWAKE;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pslverr = apb_req.psel && apb_req.penable && q.pslverr;
    assign pready = apb_req.psel && apb_req.penable;
    assign irq = q.pin_en && any_flag;
    assign standby = (q.pwr == nft_pkg::NFT_STANDBY);
endmodule : nft_timer_unit

// ### hdl/nft_tmr.sv
// One 16-bit down-counter with start, stop, events and reload
`timescale 1ns/1ns
module nft_tmr (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire logic start_evt,
    input wire logic stop_evt,
    input nft_pkg::nft_tcfg_t cfg,
    input wire logic [15:0] reload,
    output logic [15:0] count,
    output logic counting,
    output logic waiting,
    output logic underflow
);
    nft_pkg::nft_tmr_st_t st_q;
    nft_pkg::nft_tmr_st_t st_d;
    logic uf;

    always_comb begin
        st_d = st_q;
        uf = 1'b0;
        if (start) begin
            st_d.count = reload;
            st_d.waiting = cfg.start_evt_en;
            st_d.counting = !cfg.start_evt_en;
        end else if (stop) begin
            st_d.counting = 1'b0;
            st_d.waiting = 1'b0;
        end else if (st_q.waiting && start_evt) begin
            st_d.waiting = 1'b0;
            st_d.counting = 1'b1;
        end else if (st_q.counting && cfg.stop_evt_en && stop_evt) begin
            // Stop beats a same-cycle tick, so no interrupt and count frozen
            st_d.counting = 1'b0;
        end else if (st_q.counting && tick) begin
            if (st_q.count == 16'h0000) begin
                uf = 1'b1;
                if (cfg.auto_reload) begin
                    st_d.count = reload;
                end else begin
                    st_d.counting = 1'b0;
                end
            end else begin
                st_d.count = st_q.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count = st_q.count;
    assign counting = st_q.counting;
    assign waiting = st_q.waiting;
    assign underflow = uf;
endmodule : nft_tmr

// ### test/nft_timer_unit_assertions.sv
// Port-level checks of the timer unit's bus, interrupt and standby behaviour
`timescale 1ns/1ns
module nft_timer_unit_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input nft_pkg::nft_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic slow_osc,
    input wire logic [3:0] start_evt,
    input wire logic [3:0] stop_evt,
    input wire logic card_found,
    input wire logic detect_done,
    input wire logic irq,
    input wire logic standby
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence acc_s;
        apb_req.psel && apb_req.penable;
    endsequence
    sequence wr_s(a);
        acc_s ##0 apb_req.pwrite && apb_req.paddr == a;
    endsequence
    a_ready_access: assert property (acc_s |-> pready)
        else $error("no ready in access cycle");
    a_ready_idle: assert property (!apb_req.penable |-> !pready && !pslverr)
        else $error("ready or error outside access");
    a_misalign_err: assert property (acc_s ##0 apb_req.paddr[1:0] != 2'h0
        |-> pslverr && (apb_req.pwrite || prdata == 32'h0))
        else $error("unaligned access not refused");
    a_unmapped_err: assert property (acc_s ##0 apb_req.paddr == 8'h14 |-> pslverr)
        else $error("unmapped access not refused");
    a_rdata_hold: assert property (acc_s ##0 !apb_req.pwrite |=> $stable(prdata))
        else $error("read data moved after access");
    a_irq_masked: assert property (wr_s(8'h08) ##0 !apb_req.pwdata[6] |=> !irq)
        else $error("irq high with pin disabled");
    // Standby only through software or an empty detection pass
    a_standby_cause: assert property ($rose(standby) |-> $past(apb_req.psel && apb_req.penable
        && apb_req.pwrite && apb_req.paddr == 8'h0C && apb_req.pwdata[0])
        || $past(detect_done && !card_found))
        else $error("standby entered without cause");
    a_found_awake: assert property (!standby && detect_done && card_found
        && !(apb_req.psel && apb_req.pwrite) |=> !standby)
        else $error("standby after card found");
endmodule : nft_timer_unit_assertions

bind nft_timer_unit nft_timer_unit_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_osc(slow_osc), .start_evt(start_evt), .stop_evt(stop_evt),
    .card_found(card_found), .detect_done(detect_done), .irq(irq), .standby(standby));

// ### test/tb.sv
// Self-checking bench for the timer unit
`timescale 1ns/1ns
module tb;
    logic pclk, presetn, slow_osc, card_found, detect_done, pready, pslverr, irq, standby, er;
    logic [3:0] start_evt, stop_evt;
    logic [31:0] prdata, rd;
    logic [7:0] b;
    nft_pkg::nft_apb_req_t req;
    int bad_count, n_tests, n, i;
    `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
        $display("BAD %s exp %h got %h", nm, e, g); end end
    nft_timer_unit uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slow_osc(slow_osc), .start_evt(start_evt),
        .stop_evt(stop_evt), .card_found(card_found), .detect_done(detect_done), .irq(irq),
        .standby(standby));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Slow oscillator free-runs, 40 pclk period
    always begin
        repeat (20) @(posedge pclk);
        slow_osc <= ~slow_osc;
    end
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    // Idle cycle after each transfer keeps request drives one per time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin bad_count++; end_sim(); end
        rd = prdata;
        er = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd & m)
    endtask : chk_rd
    task automatic wait_sig(input bit sb, input logic lvl, input int lim);
        n = 0;
        while ((sb ? standby : irq) !== lvl && n < lim) begin @(posedge pclk); n++; end
        if (n >= lim) begin bad_count++; $display("BAD wait exp %h got %h", lvl, ~lvl); end_sim(); end
    endtask : wait_sig
    task automatic detect(input logic f);
        card_found <= f;
        detect_done <= 1'b1;
        @(posedge pclk);
        detect_done <= 1'b0;
        @(posedge pclk);
    endtask : detect
    function automatic int per(input logic [1:0] sel, input int up);
        return sel == 2'h0 ? 7 + up : sel == 2'h1 ? 471 + up : 80;
    endfunction : per
    task automatic oneshot(input int t, input logic [1:0] sel, input logic [15:0] r);
        logic [7:0] tb_base;
        tb_base = 8'(32 * (t + 1));
        apb(1'b1, tb_base + 8'h04, {24'h0, r[15:8]});
        apb(1'b1, tb_base + 8'h08, {24'h0, r[7:0]});
        apb(1'b1, tb_base, {30'h0, sel});
        apb(1'b1, 8'h08, 32'h40 | (32'h1 << t));
        apb(1'b1, 8'h00, 32'h11 << t);
        chk_rd("running", 8'h00, 32'h1 << t, 32'h1 << t);
        wait_sig(0, 1'b1, 20000);
        // Flag lands r+1 ticks after start, counted from the start edge
        `CHK("period", 1'b1, n + 4 >= r * per(sel, 0) && n + 4 <= (r + 1) * per(sel, 1) + 8)
        chk_rd("flags", 8'h04, 32'h4F, 32'h40 | (32'h1 << t));
        chk_rd("stopped", 8'h00, 32'h1 << t, 32'h0);
        chk_rd("count", tb_base + 8'h10, 32'hFF, 32'h0);
        apb(1'b1, 8'h04, 32'h1 << t);
        `CHK("irq clear", 1'b0, irq)
        apb(1'b1, 8'h04, 32'h80 | (32'h1 << t));
        `CHK("irq set", 1'b1, irq)
        apb(1'b1, 8'h08, 32'h1 << t);
        `CHK("irq pin off", 1'b0, irq)
        apb(1'b1, 8'h04, 32'h1 << t);
    endtask : oneshot
    initial begin
        {presetn, slow_osc, card_found, detect_done, start_evt, stop_evt} = '0;
        req = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        n = $urandom(32'h98781FF4);
        for (i = 0; i < 5; i++) chk_rd("reload rst", 8'(32 * i + 36), 32'hFF, 32'hFF);
        chk_rd("ctrl rst", 8'h00, 32'h1F0F, 32'h0);
        for (i = 0; i < 3; i++) begin
            apb(1'b0, i == 0 ? 8'h14 : i == 1 ? 8'h21 : 8'h34, 32'h0);
            `CHK("refused", 33'h100000000, {er, rd})
        end
        for (i = 0; i < 3; i++) oneshot(0, 2'h0, 16'($urandom_range(9, 1)));
        oneshot(1, 2'h1, 16'h1);
        apb(1'b1, 8'h48, 32'h2);
        apb(1'b1, 8'h44, 32'h0);
        apb(1'b1, 8'h40, 32'h0C);
        apb(1'b1, 8'h08, 32'h42);
        repeat (3) begin
            wait_sig(0, 1'b1, 100);
            `CHK("reperiod", 1'b1, n < 40)
            apb(1'b1, 8'h04, 32'h2);
        end
        chk_rd("reloaded", 8'h00, 32'h2, 32'h2);
        apb(1'b1, 8'h00, 32'h20);
        chk_rd("halted", 8'h00, 32'h2, 32'h0);
        apb(1'b1, 8'h40, 32'h0C);
        apb(1'b1, 8'h40, 32'h84);
        chk_rd("ctrl halt", 8'h00, 32'h2, 32'h0);
        apb(1'b1, 8'h64, 32'h1);
        apb(1'b1, 8'h68, 32'h0);
        apb(1'b1, 8'h60, 32'h30);
        apb(1'b1, 8'h00, 32'h44);
        chk_rd("waiting", 8'h00, 32'h404, 32'h400);
        chk_rd("loaded", 8'h6C, 32'hFF, 32'h1);
        start_evt <= 4'h4;
        @(posedge pclk);
        start_evt <= 4'h0;
        repeat (40) @(posedge pclk);
        chk_rd("started", 8'h00, 32'h404, 32'h4);
        stop_evt <= 4'h4;
        @(posedge pclk);
        stop_evt <= 4'h0;
        apb(1'b0, 8'h70, 32'h0);
        b = rd[7:0];
        `CHK("elapsed", 1'b1, b >= 8'hF8 && b <= 8'hFC)
        repeat (20) @(posedge pclk);
        chk_rd("frozen", 8'h70, 32'hFF, {24'h0, b});
        chk_rd("no flag", 8'h04, 32'h4, 32'h0);
        chk_rd("stop", 8'h00, 32'h4, 32'h0);
        apb(1'b1, 8'hA8, 32'h1);
        apb(1'b1, 8'hA4, 32'h0);
        apb(1'b1, 8'hA0, 32'h4C);
        chk_rd("wake run", 8'h00, 32'h1000, 32'h1000);
        apb(1'b1, 8'h0C, 32'h1);
        `CHK("standby", 1'b1, standby)
        wait_sig(1, 1'b0, 200);
        chk_rd("check", 8'h0C, 32'h3, 32'h2);
        detect(1'b0);
        `CHK("restandby", 1'b1, standby)
        apb(1'b1, 8'hA0, 32'h04);
        wait_sig(1, 1'b0, 200);
        detect(1'b0);
        `CHK("stay awake", 1'b0, standby)
        detect(1'b1);
        oneshot(3, 2'h2, 16'h1);
        end_sim();
    end
endmodule : tb
